// *** src/ncsd_pkg.sv ***
// shared constants and types of the node and line method switch decoder
package ncsd_pkg;
  localparam int CLOCK_HZ = 40_000_000;
  localparam int TERM_BAUD = 9600;
  localparam int NORMAL_BAUD = 19200;
  localparam logic [15:0] TERM_BAUD_DIV = 16'(CLOCK_HZ / TERM_BAUD);
  localparam logic [15:0] NORMAL_BAUD_DIV = 16'(CLOCK_HZ / NORMAL_BAUD);
  localparam int SHOW_TIME_MS = 2000;
  localparam int SHOW_CYCLES = (CLOCK_HZ / 1000) * SHOW_TIME_MS;

  // switch n sits at bit n-1 of the switch bus
  localparam int SW_ADDR_LSB = 0;
  localparam int SW_ADDR_W = 5;
  localparam int SW6_BIT = 5;
  localparam int SW7_BIT = 6;
  localparam int SW8_BIT = 7;
  localparam int SW10_BIT = 9;
  // keys are {sw6, sw7, sw8, sw10}
  localparam logic [3:0] KEY_THREE_WIRE = 4'h2;
  localparam logic [3:0] KEY_TWO_WIRE = 4'hd;
  localparam logic [3:0] KEY_FOUR_WIRE = 4'h1;
  localparam logic [4:0] TERMINAL_ADDRESS = 5'h00;

  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_SWITCH = 8'h04;
  localparam logic [7:0] REG_STATUS_CODE = 8'h08;
  localparam logic [7:0] REG_BAUD_DIV = 8'h0c;
  localparam int CFG_ADDR_LSB = 0;
  localparam int CFG_TERM_BIT = 8;
  localparam int CFG_METH_LSB = 12;
  localparam int CFG_VALID_BIT = 16;
  localparam int CFG_SHOW_BIT = 17;
  localparam logic [7:0] STATUS_CODE_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // segment order gfedcba, active high
  localparam logic [6:0] SEG_I = 7'h10;
  localparam logic [6:0] SEG_D = 7'h5e;
  localparam logic [6:0] SEG_BLANK = 7'h00;

  typedef enum logic [3:0] {
    METH_NONE = 4'b0001,
    METH_THREE_WIRE = 4'b0010,
    METH_TWO_WIRE = 4'b0100,
    METH_FOUR_WIRE = 4'b1000
  } ncsd_method_t;

  typedef enum logic [2:0] {
    PH_SAMPLE = 3'b001,
    PH_SHOW = 3'b010,
    PH_RUN = 3'b100
  } ncsd_phase_t;

  typedef struct packed {
    logic valid;
    logic terminal;
    ncsd_method_t method;
    logic [4:0] node_address;
    logic [9:0] raw;
    logic [15:0] baud_div;
  } ncsd_cfg_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } ncsd_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ncsd_axi_rsp_t;
endpackage

// *** src/ncsd_regs.sv ***
// axi4-lite register slave of the switch decoder
`timescale 1ns/1ps
`default_nettype none
module ncsd_regs
  import ncsd_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire ncsd_axi_req_t req_i,
  output ncsd_axi_rsp_t rsp_o,
  input wire ncsd_cfg_t cfg_i,
  input wire logic showing_i,
  output logic [7:0] status_code_o
);
  typedef struct packed {
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] status_code;
  } ncsd_regs_state_t;

  ncsd_regs_state_t state_reg;
  ncsd_regs_state_t state_next;
  logic awready;
  logic wready;
  logic arready;

  function automatic logic is_mapped(input logic [7:0] addr);
    return addr[7:2] == REG_CONFIG[7:2] || addr[7:2] == REG_SWITCH[7:2] ||
           addr[7:2] == REG_STATUS_CODE[7:2] || addr[7:2] == REG_BAUD_DIV[7:2];
  endfunction

  function automatic logic [31:0] read_word(input logic [7:0] addr, input ncsd_cfg_t c,
                                            input logic show, input logic [7:0] code);
    logic [31:0] w;
    w = 32'h0;
    if (addr[7:2] == REG_CONFIG[7:2]) begin
      w[CFG_ADDR_LSB +: 5] = c.node_address;
      w[CFG_TERM_BIT] = c.terminal;
      w[CFG_METH_LSB +: 4] = c.method;
      w[CFG_VALID_BIT] = c.valid;
      w[CFG_SHOW_BIT] = show;
    end else if (addr[7:2] == REG_SWITCH[7:2]) begin
      w[9:0] = c.raw;
    end else if (addr[7:2] == REG_STATUS_CODE[7:2]) begin
      w[7:0] = code;
    end else if (addr[7:2] == REG_BAUD_DIV[7:2]) begin
      w[15:0] = c.baud_div;
    end
    return w;
  endfunction

  always_comb begin
    state_next = state_reg;
    awready = !state_reg.aw_got && !state_reg.bvalid;
    wready = !state_reg.w_got && !state_reg.bvalid;
    arready = !state_reg.rvalid;
    if (req_i.awvalid && awready) begin
      state_next.aw_got = 1'b1;
      state_next.awaddr = req_i.awaddr;
    end
    if (req_i.wvalid && wready) begin
      state_next.w_got = 1'b1;
      state_next.wdata = req_i.wdata;
      state_next.wstrb = req_i.wstrb;
    end
    // both halves held: commit, then answer on the next cycle
    if (state_reg.aw_got && state_reg.w_got) begin
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = is_mapped(state_reg.awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (state_reg.awaddr[7:2] == REG_STATUS_CODE[7:2] && state_reg.wstrb[0]) begin
        state_next.status_code = state_reg.wdata[7:0];
      end
    end
    if (state_reg.bvalid && req_i.bready) begin
      state_next.bvalid = 1'b0;
    end
    if (req_i.arvalid && arready) begin
      state_next.rvalid = 1'b1;
      state_next.rdata = read_word(req_i.araddr, cfg_i, showing_i, state_reg.status_code);
      state_next.rresp = is_mapped(req_i.araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (state_reg.rvalid && req_i.rready) begin
      state_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_reg <= '0;
      state_reg.status_code <= STATUS_CODE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  always_comb begin
    rsp_o.awready = awready;
    rsp_o.wready = wready;
    rsp_o.bvalid = state_reg.bvalid;
    rsp_o.bresp = state_reg.bresp;
    rsp_o.arready = arready;
    rsp_o.rvalid = state_reg.rvalid;
    rsp_o.rdata = state_reg.rdata;
    rsp_o.rresp = state_reg.rresp;
  end

  assign status_code_o = state_reg.status_code;
endmodule
`default_nettype wire

// *** src/ncsd_top.sv ***
// node address and line method switch decoder with start-up display
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - switches 1 to 5 form the node address, switch 1 the lowest bit, on reading as one.
// - address zero selects terminal mode with the serial port forced to 9600 baud.
// - switch 9 only drives the termination resistor and is ignored by the method decode.
// - after power-up the display briefly shows an id prefix and the address in two decimals.
module ncsd_top
  import ncsd_pkg::*;
#(
  parameter int SHOW_LEN = SHOW_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_i,
  // contacts, read once after reset
  input wire logic [9:0] switch_i,
  // captured configuration, held until the next reset; showing_node_o marks the start-up display
  output logic [4:0] node_address_o,
  output logic terminal_mode_o,
  output logic [3:0] method_o,
  output logic [15:0] baud_div_o,
  output logic config_valid_o,
  output logic showing_node_o,
  // four digits left to right, gfedcba each
  output logic [27:0] seg_o,
  // register bus
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  typedef struct packed {
    ncsd_phase_t phase;
    ncsd_cfg_t cfg;
    logic [31:0] count;
    logic [27:0] seg;
  } ncsd_top_state_t;

  ncsd_top_state_t state_reg;
  ncsd_top_state_t state_next;
  ncsd_axi_req_t axi_req;
  ncsd_axi_rsp_t axi_rsp;
  logic [7:0] status_code;
  logic showing;
  // the full-length interval runs to tens of millions of cycles, hence 32 bits
  localparam logic [31:0] SHOW_LAST = 32'(SHOW_LEN - 1);

  function automatic logic [6:0] seg_digit(input logic [3:0] v);
    case (v)
      4'h0: return 7'h3f;
      4'h1: return 7'h06;
      4'h2: return 7'h5b;
      4'h3: return 7'h4f;
      4'h4: return 7'h66;
      4'h5: return 7'h6d;
      4'h6: return 7'h7d;
      4'h7: return 7'h07;
      4'h8: return 7'h7f;
      4'h9: return 7'h6f;
      4'ha: return 7'h77;
      4'hb: return 7'h7c;
      4'hc: return 7'h39;
      4'hd: return 7'h5e;
      4'he: return 7'h79;
      default: return 7'h71;
    endcase
  endfunction

  // key order is {sw6, sw7, sw8, sw10}; switch 9 stays out of it
  function automatic logic [3:0] method_key(input logic [9:0] sw);
    return {sw[SW6_BIT], sw[SW7_BIT], sw[SW8_BIT], sw[SW10_BIT]};
  endfunction

  function automatic ncsd_method_t decode_method(input logic [9:0] sw);
    logic [3:0] key;
    key = method_key(sw);
    case (key)
      KEY_THREE_WIRE: return METH_THREE_WIRE;
      KEY_TWO_WIRE: return METH_TWO_WIRE;
      KEY_FOUR_WIRE: return METH_FOUR_WIRE;
      default: return METH_NONE;
    endcase
  endfunction

  function automatic logic [4:0] switch_address(input logic [9:0] sw);
    return sw[SW_ADDR_LSB +: SW_ADDR_W];
  endfunction

  function automatic logic is_terminal(input logic [4:0] addr);
    return addr == TERMINAL_ADDRESS;
  endfunction

  // terminal mode overrides the normal rate only; the method decode is left alone
  function automatic logic [15:0] baud_for(input logic [4:0] addr);
    return is_terminal(addr) ? TERM_BAUD_DIV : NORMAL_BAUD_DIV;
  endfunction

  // one word of configuration from the ten contacts
  function automatic ncsd_cfg_t capture(input logic [9:0] sw);
    ncsd_cfg_t c;
    logic [4:0] addr;
    addr = switch_address(sw);
    c.valid = 1'b1;
    c.raw = sw;
    c.node_address = addr;
    c.terminal = is_terminal(addr);
    c.baud_div = baud_for(addr);
    c.method = decode_method(sw);
    return c;
  endfunction

  // compare ladder instead of a divider: the address never exceeds 31
  function automatic logic [7:0] to_decimal(input logic [4:0] addr);
    logic [3:0] tens;
    logic [3:0] ones;
    tens = (addr >= 5'd30) ? 4'h3 : (addr >= 5'd20) ? 4'h2 : (addr >= 5'd10) ? 4'h1 : 4'h0;
    ones = 4'(addr - 5'(tens * 4'ha));
    return {tens, ones};
  endfunction

  // prefix, then both decimal digits with no leading blank, so 6 reads as 06
  function automatic logic [27:0] node_word(input logic [4:0] addr);
    logic [7:0] dec;
    dec = to_decimal(addr);
    return {SEG_I, SEG_D, seg_digit(dec[7:4]), seg_digit(dec[3:0])};
  endfunction

  // left half dark while running; software status code in hex on the right
  function automatic logic [27:0] status_word(input logic [7:0] code);
    return {SEG_BLANK, SEG_BLANK, seg_digit(code[7:4]), seg_digit(code[3:0])};
  endfunction

  always_comb begin
    state_next = state_reg;
    case (state_reg.phase)
      PH_SAMPLE: begin
        // the only capture point: later switch changes are not seen until reset
        state_next.cfg = capture(switch_i);
        state_next.count = 32'h0;
        state_next.phase = PH_SHOW;
      end
      PH_SHOW: begin
        state_next.seg = node_word(state_reg.cfg.node_address);
        state_next.count = state_reg.count + 32'h1;
        if (state_reg.count == SHOW_LAST) begin
          state_next.phase = PH_RUN;
        end
      end
      PH_RUN: begin
        state_next.seg = status_word(status_code);
      end
      default: begin
        state_next.phase = PH_SAMPLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_reg <= '0;
      state_reg.phase <= PH_SAMPLE;
      state_reg.cfg.method <= METH_NONE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_comb begin
    axi_req.awvalid = s_axi_awvalid;
    axi_req.awaddr = s_axi_awaddr;
    axi_req.wvalid = s_axi_wvalid;
    axi_req.wdata = s_axi_wdata;
    axi_req.wstrb = s_axi_wstrb;
    axi_req.bready = s_axi_bready;
    axi_req.arvalid = s_axi_arvalid;
    axi_req.araddr = s_axi_araddr;
    axi_req.rready = s_axi_rready;
  end

  ncsd_regs u_regs (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .req_i(axi_req),
    .rsp_o(axi_rsp),
    .cfg_i(state_reg.cfg),
    .showing_i(showing),
    .status_code_o(status_code)
  );

  assign s_axi_awready = axi_rsp.awready;
  assign s_axi_wready = axi_rsp.wready;
  assign s_axi_bvalid = axi_rsp.bvalid;
  assign s_axi_bresp = axi_rsp.bresp;
  assign s_axi_arready = axi_rsp.arready;
  assign s_axi_rvalid = axi_rsp.rvalid;
  assign s_axi_rdata = axi_rsp.rdata;
  assign s_axi_rresp = axi_rsp.rresp;

  assign node_address_o = state_reg.cfg.node_address;
  assign terminal_mode_o = state_reg.cfg.terminal;
  assign method_o = state_reg.cfg.method;
  assign baud_div_o = state_reg.cfg.baud_div;
  assign config_valid_o = state_reg.cfg.valid;
  assign showing = state_reg.phase == PH_SHOW;
  assign showing_node_o = showing;
  assign seg_o = state_reg.seg;
endmodule
`default_nettype wire

// *** dv/ncsd_properties.sv ***
// concurrent checks on the switch decoder ports
`timescale 1ns/1ps
`default_nettype none
module ncsd_properties
  import ncsd_pkg::*;
#(
  parameter int SHOW_LEN = 8
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [9:0] switch_i,
  input wire logic [4:0] node_address_o,
  input wire logic terminal_mode_o,
  input wire logic [3:0] method_o,
  input wire logic [15:0] baud_div_o,
  input wire logic config_valid_o,
  input wire logic showing_node_o,
  input wire logic [27:0] seg_o
);
  localparam logic [6:0] DIG [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d,
    7'h07, 7'h7f, 7'h6f};
  logic [31:0] show_cnt;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // switch 9 never enters the key
  function automatic logic [3:0] meth(input logic [9:0] s);
    case ({s[5], s[6], s[7], s[9]})
      4'h2: return 4'b0010;
      4'hd: return 4'b0100;
      4'h1: return 4'b1000;
      default: return 4'b0001;
    endcase
  endfunction
  always_ff @(posedge clock_i) begin
    if (rst_i)
      show_cnt <= '0;
    else if (showing_node_o)
      show_cnt <= show_cnt + 1;
  end
  sequence s_boot;
    config_valid_o && showing_node_o;
  endsequence
  sequence s_id;
    seg_o[27:14] == {SEG_I, SEG_D};
  endsequence
  a_boot_order: assert property ($fell(rst_i) |=> s_boot ##1 s_id)
    else $error("start-up display order wrong");
  a_addr_take: assert property ($rose(config_valid_o) |-> node_address_o == 5'($past(switch_i)))
    else $error("node address not taken from switches");
  a_method_key: assert property ($rose(config_valid_o) |-> method_o == meth($past(switch_i)))
    else $error("line method decode wrong");
  a_term_baud: assert property (config_valid_o |-> terminal_mode_o == (node_address_o ==
    TERMINAL_ADDRESS) && baud_div_o == ((node_address_o == TERMINAL_ADDRESS) ? TERM_BAUD_DIV :
    NORMAL_BAUD_DIV))
    else $error("terminal mode or bit rate wrong");
  a_cfg_hold: assert property (config_valid_o |=> config_valid_o && $stable(node_address_o)
    && $stable(method_o) && $stable(baud_div_o))
    else $error("configuration changed before reset");
  a_show_digits: assert property (showing_node_o && $past(showing_node_o) |-> seg_o ==
    {SEG_I, SEG_D, DIG[node_address_o / 10], DIG[node_address_o % 10]})
    else $error("node display digits wrong");
  a_show_len: assert property ($fell(showing_node_o) |-> show_cnt == 32'(SHOW_LEN))
    else $error("node display interval wrong");
endmodule
`default_nettype wire

// *** dv/ncsd_switch_bank.sv ***
// dip switch bank that the operator sets
`timescale 1ns/1ps
`default_nettype none
module ncsd_switch_bank (
  input wire logic clock_i,
  input wire logic [9:0] setting_i,
  output logic [9:0] switch_o
);
  initial switch_o = 10'h000;
  // contacts move only when the bench turns them; set before release of reset
  always @(posedge clock_i) begin
    switch_o <= setting_i;
  end
endmodule
`default_nettype wire

// *** dv/ncsd_top_tb.sv ***
// self-checking bench of the switch decoder
`timescale 1ns/1ps
`default_nettype none
module ncsd_top_tb
  import ncsd_pkg::*;
;
  localparam int LEN = 8;
  localparam logic [6:0] DIG [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
    7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79, 7'h71};
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [9:0] setting = 10'h000;
  logic [9:0] switch_i;
  logic [4:0] node_address_o;
  logic terminal_mode_o, config_valid_o, showing_node_o;
  logic [3:0] method_o;
  logic [15:0] baud_div_o;
  logic [27:0] seg_o;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  always #12.5 clock_i = ~clock_i;
  ncsd_switch_bank bank_u (.clock_i, .setting_i(setting), .switch_o(switch_i));
  ncsd_top #(.SHOW_LEN(LEN)) dut_u (.clock_i, .rst_i, .switch_i, .node_address_o,
    .terminal_mode_o, .method_o, .baud_div_o, .config_valid_o, .showing_node_o, .seg_o,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok = 1'b0;
    logic w_ok = 1'b0;
    @(posedge clock_i);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clock_i);
      if (s_axi_awready === 1'b1 && !aw_ok) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1 && !w_ok) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clock_i); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clock_i); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock_i); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // reset with the switches set, then turn them all over while the address is still on show
  task automatic t_boot(input logic [9:0] sw, input logic [3:0] m);
    logic [4:0] a;
    a = sw[4:0];
    setting <= sw;
    rst_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    #1;
    chk(config_valid_o, 1, "valid");
    chk(node_address_o, a, "address");
    chk(terminal_mode_o, a == 5'h00, "terminal");
    chk(baud_div_o, a == 5'h00 ? TERM_BAUD_DIV : NORMAL_BAUD_DIV, "divider");
    chk(method_o, m, "method");
    chk(seg_o, {SEG_I, SEG_D, DIG[a / 10], DIG[a % 10]}, "id digits");
    chk(showing_node_o, 1, "showing start");
    setting <= ~sw;
    repeat (LEN + 4) @(posedge clock_i);
    #1;
    chk(showing_node_o, 0, "showing");
    chk({node_address_o, method_o}, {a, m}, "held");
    chk(seg_o, {SEG_BLANK, SEG_BLANK, DIG[STATUS_CODE_RESET[7:4]],
      DIG[STATUS_CODE_RESET[3:0]]}, "run digits");
    $display("test boot %h done", sw);
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    wr(REG_STATUS_CODE, 32'h5a, r);
    chk(r, RESP_OKAY, "write resp");
    wr(REG_CONFIG, 32'hffffffff, r);
    chk(r, RESP_OKAY, "read-only write resp");
    wr(8'h10, 32'h1, r);
    chk(r, RESP_SLVERR, "unmapped write resp");
    repeat (2) @(posedge clock_i);
    #1;
    chk(seg_o, {SEG_BLANK, SEG_BLANK, DIG[5], DIG[10]}, "status digits");
    rd(REG_CONFIG, d, r);
    chk(d, 32'h00012011, "config");
    chk(r, RESP_OKAY, "config resp");
    rd(REG_SWITCH, d, r);
    chk(d, 32'h00000191, "switch copy");
    rd(REG_BAUD_DIV, d, r);
    chk(d, {16'h0, NORMAL_BAUD_DIV}, "divider copy");
    rd(REG_STATUS_CODE, d, r);
    chk(d, 32'h0000005a, "status copy");
    rd(8'h10, d, r);
    chk(r, RESP_SLVERR, "unmapped resp");
    chk(d, 32'h0, "unmapped data");
    $display("test regs done");
  endtask
  initial begin
    t_boot(10'h086, 4'b0010);
    t_boot(10'h260, 4'b0100);
    t_boot(10'h31f, 4'b1000);
    t_boot(10'h370, 4'b0100);
    t_boot(10'h001, 4'b0001);
    t_boot(10'h191, 4'b0010);
    t_regs();
    report_and_stop();
  end
endmodule
bind ncsd_top ncsd_properties #(.SHOW_LEN(SHOW_LEN)) prop_u (.clock_i, .rst_i, .switch_i,
  .node_address_o, .terminal_mode_o, .method_o, .baud_div_o, .config_valid_o,
  .showing_node_o, .seg_o);
`default_nettype wire
